// >>> shared/accalu_pkg.sv
// Constants, register map and instruction encoding for the accumulator ALU block
package accalu_pkg;

  // ==========================================================================
  // APB register byte offsets
  localparam logic [7:0] ADDR_INSTR = 8'h00;
  localparam logic [7:0] ADDR_ACC = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_FILE_PTR = 8'h0C;
  localparam logic [7:0] ADDR_FILE_DATA = 8'h10;

  // ==========================================================================
  // Instruction word fields
  localparam int OP_LSB = 0;
  localparam int DEST_BIT = 4;
  localparam int BSEL_LSB = 5;
  localparam int FADDR_LSB = 8;
  localparam int LIT_LSB = 16;

  // ==========================================================================
  // Operation codes
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_ADD_IMM = 4'h1;
  localparam logic [3:0] OP_ADD_REG = 4'h2;
  localparam logic [3:0] OP_AND_IMM = 4'h3;
  localparam logic [3:0] OP_AND_REG = 4'h4;
  localparam logic [3:0] OP_BIT_CLR = 4'h5;
  localparam logic [3:0] OP_BIT_SET = 4'h6;
  localparam logic [3:0] OP_TEST_SKIP = 4'h7;

  // ==========================================================================
  // Status bit positions
  localparam int ST_CARRY = 0;
  localparam int ST_DIGIT = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_SKIP = 3;
  localparam int ST_BUSY = 4;

  // ==========================================================================
  // File space and special addresses
  localparam int FILE_DEPTH = 128;
  localparam logic [6:0] TIMER_ZERO_ADDR = 7'h01;
  localparam logic [6:0] PORT_ADDR = 7'h05;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] FILE_RST = 8'h00;
  localparam logic [31:0] INSTR_RST = 32'h0000_0000;

endpackage

// >>> shared/accalu_alu_if.sv
// Operand and result bundle between the core and the execution unit
`timescale 1ns/1ns
interface accalu_alu_if;
  logic [3:0] op;
  logic dest;
  logic [2:0] bit_sel;
  logic [7:0] acc;
  logic [7:0] src;
  logic [7:0] lit;
  logic [7:0] result;
  logic carry;
  logic digit_carry_flag;
  logic zero;
  logic upd_carry;
  logic upd_digit;
  logic upd_zero;
  logic wr_acc;
  logic wr_file;
  logic skip;

  modport core (
    output op, dest, bit_sel, acc, src, lit,
    input result, carry, digit_carry_flag, zero, upd_carry, upd_digit, upd_zero,
    input wr_acc, wr_file, skip
  );
  modport exec (
    input op, dest, bit_sel, acc, src, lit,
    output result, carry, digit_carry_flag, zero, upd_carry, upd_digit, upd_zero,
    output wr_acc, wr_file, skip
  );
endinterface

// >>> rtl/accalu_exec.sv
// Combinational execution unit: arithmetic, logic and bit operations
`timescale 1ns/1ns
module accalu_exec
  import accalu_pkg::*;
(
  accalu_alu_if.exec alu
);

  // ==========================================================================
  // Operand selection and adders
  wire imm_op = (alu.op == OP_ADD_IMM) || (alu.op == OP_AND_IMM);
  wire [7:0] opnd_b = imm_op ? alu.lit : alu.src;
  wire [8:0] sum9 = {1'b0, alu.acc} + {1'b0, opnd_b};
  wire [4:0] low5 = {1'b0, alu.acc[3:0]} + {1'b0, opnd_b[3:0]};
  wire [7:0] and8 = alu.acc & opnd_b;
  wire [7:0] bit_mask = 8'h01 << alu.bit_sel;

  // ==========================================================================
  // Operation decode
  always_comb
  begin
    alu.result = 8'h00;
    alu.upd_carry = 1'b0;
    alu.upd_digit = 1'b0;
    alu.upd_zero = 1'b0;
    alu.wr_acc = 1'b0;
    alu.wr_file = 1'b0;
    alu.skip = 1'b0;
    case (alu.op)
      OP_ADD_IMM:
      begin
        alu.result = sum9[7:0];
        alu.upd_carry = 1'b1;
        alu.upd_digit = 1'b1;
        alu.upd_zero = 1'b1;
        alu.wr_acc = 1'b1;
      end
      OP_ADD_REG:
      begin
        alu.result = sum9[7:0];
        alu.upd_carry = 1'b1;
        alu.upd_digit = 1'b1;
        alu.upd_zero = 1'b1;
        alu.wr_acc = ~alu.dest;
        alu.wr_file = alu.dest;
      end
      OP_AND_IMM:
      begin
        alu.result = and8;
        alu.upd_zero = 1'b1;
        alu.wr_acc = 1'b1;
      end
      OP_AND_REG:
      begin
        alu.result = and8;
        alu.upd_zero = 1'b1;
        alu.wr_acc = ~alu.dest;
        alu.wr_file = alu.dest;
      end
      OP_BIT_CLR:
      begin
        alu.result = alu.src & ~bit_mask;
        alu.wr_file = 1'b1;
      end
      OP_BIT_SET:
      begin
        alu.result = alu.src | bit_mask;
        alu.wr_file = 1'b1;
      end
      OP_TEST_SKIP:
      begin
        // No flag update and no write; only the skip request
        alu.skip = ~alu.src[alu.bit_sel];
      end
      default:
      begin
        alu.result = 8'h00;
      end
    endcase
  end

  assign alu.carry = sum9[8];
  assign alu.digit_carry_flag = low5[4];
  assign alu.zero = (alu.result == 8'h00);

endmodule

// >>> rtl/accalu_top.sv
// Accumulator ALU core with file registers, reached over APB
`timescale 1ns/1ns

// Behaviour
// - Add-immediate adds a literal to the accumulator, updating carry, digit carry and zero.
// - Add-register sums accumulator and file register, same three flags, dest bit picks target.
// - And-immediate ANDs accumulator with a literal into the accumulator, updating only Z.
// - And-register ANDs accumulator with a file register, only Z changes, destination bit picks target.
// - Bit-clear zeroes one bit of a file register and leaves other bits and flags alone.
// - Bit-set sets one bit of a file register and leaves other bits and flags alone.
// - Test-skip with the bit at one lets the next instruction run and changes no flags.
// - Test-skip with the bit at zero turns the next instruction into a no-operation.
// - A register operand taken from the I/O port reads the pin levels, not the latch.
// - An instruction's file write to the timer zero count clears the prescaler when it belongs to the timer; bus writes do not.
module accalu_top
  import accalu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] port_pins,
  output logic [7:0] port_latch,
  input wire logic prescaler_on_timer,
  output logic prescaler_clear
);

  // ==========================================================================
  // State
  logic [7:0] file_mem [FILE_DEPTH];
  logic [7:0] acc_r;
  logic carry_r;
  logic digit_r;
  logic zero_r;
  logic skip_pending_r;
  logic exec_valid_r;
  logic [31:0] instr_r;
  logic [6:0] file_ptr_r;
  logic [7:0] pin_meta_r;
  logic [7:0] pin_sync_r;
  logic rd_wait_r;
  logic [31:0] prdata_r;
  logic prescaler_clear_r;

  accalu_alu_if alu ();

  accalu_exec u_exec (
    .alu(alu)
  );

  // ==========================================================================
  // Bus decode
  wire bus_access = psel & penable;
  wire hit_instr = (paddr == ADDR_INSTR);
  wire hit_acc = (paddr == ADDR_ACC);
  wire hit_status = (paddr == ADDR_STATUS);
  wire hit_ptr = (paddr == ADDR_FILE_PTR);
  wire hit_data = (paddr == ADDR_FILE_DATA);
  wire hit_any = hit_instr | hit_acc | hit_status | hit_ptr | hit_data;
  // Reads take one wait state so prdata comes from a flop
  wire bus_done = bus_access & (pwrite | rd_wait_r);
  wire wr_en = bus_done & pwrite & hit_any;
  wire wr_instr = wr_en & hit_instr;
  wire wr_acc_bus = wr_en & hit_acc;
  wire wr_status_bus = wr_en & hit_status;
  wire wr_ptr_bus = wr_en & hit_ptr;
  wire wr_data_bus = wr_en & hit_data;
  wire rd_capture = bus_access & ~pwrite & ~rd_wait_r;

  wire [7:0] status_byte = {3'b000, exec_valid_r, skip_pending_r, zero_r, digit_r, carry_r};
  wire [31:0] rd_mux = hit_instr ? instr_r :
                       hit_acc ? {24'h000000, acc_r} :
                       hit_status ? {24'h000000, status_byte} :
                       hit_ptr ? {25'h0000000, file_ptr_r} :
                       hit_data ? {24'h000000, file_mem[file_ptr_r]} : 32'h0000_0000;

  assign pready = pwrite | rd_wait_r;
  assign pslverr = bus_done & ~hit_any;
  assign prdata = prdata_r;

  // ==========================================================================
  // Operand fetch
  wire [6:0] f_addr = instr_r[FADDR_LSB +: 7];
  // Port source is the pins, so a read-modify-write picks up external levels
  wire [7:0] f_value = (f_addr == PORT_ADDR) ? pin_sync_r : file_mem[f_addr];

  assign alu.op = instr_r[OP_LSB +: 4];
  assign alu.dest = instr_r[DEST_BIT];
  assign alu.bit_sel = instr_r[BSEL_LSB +: 3];
  assign alu.acc = acc_r;
  assign alu.src = f_value;
  assign alu.lit = instr_r[LIT_LSB +: 8];

  // A slot issued while a skip is pending is discarded as a no-operation
  wire exec_go = exec_valid_r & ~skip_pending_r;
  wire do_acc = exec_go & alu.wr_acc;
  wire do_file = exec_go & alu.wr_file;
  wire timer_hit = do_file & (f_addr == TIMER_ZERO_ADDR) & prescaler_on_timer;

  assign port_latch = file_mem[PORT_ADDR];
  assign prescaler_clear = prescaler_clear_r;

  // ==========================================================================
  // Pin synchroniser
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta_r <= 8'h00;
      pin_sync_r <= 8'h00;
    end
    else
    begin
      pin_meta_r <= port_pins;
      pin_sync_r <= pin_meta_r;
    end
  end

  // ==========================================================================
  // Bus side registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_wait_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      instr_r <= INSTR_RST;
      exec_valid_r <= 1'b0;
      file_ptr_r <= 7'h00;
    end
    else
    begin
      rd_wait_r <= rd_capture;
      if (rd_capture)
        prdata_r <= rd_mux;
      if (wr_instr)
        instr_r <= pwdata;
      exec_valid_r <= wr_instr;
      if (wr_ptr_bus)
        file_ptr_r <= pwdata[6:0];
    end
  end

  // ==========================================================================
  // Accumulator, flags and skip
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_r <= ACC_RST;
      carry_r <= 1'b0;
      digit_r <= 1'b0;
      zero_r <= 1'b0;
      skip_pending_r <= 1'b0;
      prescaler_clear_r <= 1'b0;
    end
    else
    begin
      if (do_acc)
        acc_r <= alu.result;
      else if (wr_acc_bus)
        acc_r <= pwdata[7:0];
      // Execution has priority over a software write of the same flag
      if (exec_go & alu.upd_carry)
        carry_r <= alu.carry;
      else if (wr_status_bus)
        carry_r <= pwdata[ST_CARRY];
      if (exec_go & alu.upd_digit)
        digit_r <= alu.digit_carry_flag;
      else if (wr_status_bus)
        digit_r <= pwdata[ST_DIGIT];
      if (exec_go & alu.upd_zero)
        zero_r <= alu.zero;
      else if (wr_status_bus)
        zero_r <= pwdata[ST_ZERO];
      if (exec_valid_r)
        skip_pending_r <= exec_go & alu.skip;
      prescaler_clear_r <= timer_hit;
    end
  end

  // ==========================================================================
  // File registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < FILE_DEPTH; i++)
        file_mem[i] <= FILE_RST;
    end
    else if (do_file)
      file_mem[f_addr] <= alu.result;
    else if (wr_data_bus)
      file_mem[file_ptr_r] <= pwdata[7:0];
  end

endmodule

// >>> verif/accalu_checker.sv
// Port assertions for the accumulator ALU core
`timescale 1ns/1ns
module accalu_checker
  import accalu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] port_pins,
  input wire logic [7:0] port_latch,
  input wire logic prescaler_on_timer,
  input wire logic prescaler_clear
);
  // ==========
  // Output timing and causes
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc_w = psel && penable && pwrite;
  wire ins_w = acc_w && paddr == ADDR_INSTR;
  wire dat_w = acc_w && paddr == ADDR_FILE_DATA;
  wire unmapped = paddr[1:0] != 2'h0 || paddr > ADDR_FILE_DATA;
  a_write_no_wait: assert property (acc_w |-> pready) else $error("write stalled");
  a_read_one_wait: assert property (psel && penable && !pwrite && !$past(penable)
    |-> !pready ##1 pready) else $error("read wait wrong");
  a_err_unmapped: assert property (psel && penable && pready |-> pslverr == unmapped)
    else $error("error response wrong");
  a_prdata_hold: assert property ($changed(prdata) |-> $past(psel && penable && !pwrite))
    else $error("read data moved");
  a_latch_cause: assert property ($changed(port_latch) |-> $past(ins_w, 2) || $past(dat_w))
    else $error("latch moved without cause");
  a_clear_timer: assert property (prescaler_clear |-> $past(prescaler_on_timer))
    else $error("clear while not assigned");
  a_clear_issue: assert property (prescaler_clear |-> $past(ins_w, 2))
    else $error("clear without instruction");
  a_clear_pulse: assert property (prescaler_clear |=> !prescaler_clear)
    else $error("clear too long");
endmodule
bind accalu_top accalu_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .port_pins(port_pins), .port_latch(port_latch),
  .prescaler_on_timer(prescaler_on_timer), .prescaler_clear(prescaler_clear));

// >>> verif/accum_alu_bit_ops_subset_tb_top.sv
// Self-checking bench for the accumulator ALU core
`timescale 1ns/1ns
module accum_alu_bit_ops_subset_tb_top
  import accalu_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, port_pins = 8'h00, port_latch, m_acc = 8'h00, p;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic on_t = 1'b0, pready, pslverr, clr, er;
  logic m_c = 1'b0, m_dig = 1'b0, m_z = 1'b0, m_skip = 1'b0;
  logic [7:0] m_mem [128];
  logic [6:0] f;
  int n_errors = 0, compares = 0, cycles = 0, n_clr = 0, c0;
  always #5 pclk = ~pclk;
  accalu_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_pins(port_pins), .port_latch(port_latch),
    .prescaler_on_timer(on_t), .prescaler_clear(clr));
  // ==========
  // Bus and compare tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // Edge first, so the previous release never collides with this setup
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Answer and read data are taken at the completing rising edge only
    while (pready !== 1'b1 && cycles < 20000)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] ins(logic [3:0] o, logic d, logic [2:0] b, logic [6:0] a,
    logic [7:0] k);
    return {8'h00, k, 1'b0, a, b, d, o};
  endfunction
  // A pending skip swallows whatever comes next, nop included
  function automatic void model(input logic [31:0] iw);
    logic [3:0] o;
    logic [7:0] s, x, r;
    logic [8:0] sum;
    logic [4:0] h;
    o = iw[3:0];
    s = m_mem[iw[14:8]];
    x = (o == OP_ADD_IMM || o == OP_AND_IMM) ? iw[23:16] : s;
    sum = {1'b0, m_acc} + {1'b0, x};
    h = {1'b0, m_acc[3:0]} + {1'b0, x[3:0]};
    r = (o <= OP_ADD_REG) ? sum[7:0] : (m_acc & x);
    if (m_skip)
      m_skip = 1'b0;
    else if (o >= OP_ADD_IMM && o <= OP_AND_REG)
    begin
      m_c = (o <= OP_ADD_REG) ? sum[8] : m_c;
      m_dig = (o <= OP_ADD_REG) ? h[4] : m_dig;
      m_z = r == 8'h00;
      if (o == OP_ADD_IMM || o == OP_AND_IMM || !iw[4])
        m_acc = r;
      else
        m_mem[iw[14:8]] = r;
    end
    else if (o == OP_BIT_CLR)
      m_mem[iw[14:8]] = s & ~(8'h01 << iw[7:5]);
    else if (o == OP_BIT_SET)
      m_mem[iw[14:8]] = s | (8'h01 << iw[7:5]);
    else if (o == OP_TEST_SKIP)
      m_skip = !s[iw[7:5]];
  endfunction
  task automatic run(input logic [31:0] iw);
    apb(1'b1, ADDR_INSTR, iw);
    model(iw);
    apb(1'b0, ADDR_ACC, 32'h0);
    check(rd, {24'h0, m_acc});
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd, {27'h0, 1'b0, m_skip, m_z, m_dig, m_c});
    apb(1'b1, ADDR_FILE_PTR, {25'h0, iw[14:8]});
    apb(1'b0, ADDR_FILE_DATA, 32'h0);
    check(rd, {24'h0, m_mem[iw[14:8]]});
  endtask
  task automatic summarize();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (clr === 1'b1)
      n_clr <= n_clr + 1;
    if (cycles == 20000)
    begin
      n_errors++;
      summarize();
    end
  end
  // ==========
  // Main sequence
  initial
  begin
    foreach (m_mem[i])
      m_mem[i] = 8'h00;
    void'($urandom(56306));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    run(ins(OP_ADD_IMM, 1'b0, 3'h0, 7'h08, 8'h0F));
    run(ins(OP_ADD_IMM, 1'b0, 3'h0, 7'h08, 8'hF1));
    run(ins(OP_AND_IMM, 1'b0, 3'h0, 7'h08, 8'hFF));
    $display("corners done");
    repeat (70)
    begin
      f = ($urandom_range(3) == 0) ? 7'h7F : 7'($urandom_range(23, 8));
      run(ins(4'($urandom_range(8, 0)), 1'($urandom), 3'($urandom), f, 8'($urandom)));
    end
    $display("random done");
    apb(1'b1, 8'h14, 32'hFF);
    check({31'h0, er}, 32'h1);
    apb(1'b1, ADDR_INSTR, 32'h0);
    c0 = n_clr;
    on_t <= 1'b1;
    apb(1'b1, ADDR_INSTR, ins(OP_BIT_SET, 1'b0, 3'h2, TIMER_ZERO_ADDR, 8'h00));
    apb(1'b1, ADDR_INSTR, ins(OP_ADD_REG, 1'b0, 3'h0, TIMER_ZERO_ADDR, 8'h00));
    on_t <= 1'b0;
    apb(1'b1, ADDR_INSTR, ins(OP_BIT_CLR, 1'b0, 3'h2, TIMER_ZERO_ADDR, 8'h00));
    repeat (3) @(posedge pclk);
    check(32'(n_clr - c0), 32'h1);
    $display("timer done");
    p = 8'($urandom) & 8'hFE;
    port_pins <= p;
    apb(1'b1, ADDR_FILE_PTR, 32'h5);
    apb(1'b1, ADDR_FILE_DATA, {24'h0, ~p});
    apb(1'b1, ADDR_ACC, 32'h0);
    check({24'h0, port_latch}, {24'h0, ~p});
    apb(1'b1, ADDR_INSTR, ins(OP_ADD_REG, 1'b0, 3'h0, PORT_ADDR, 8'h00));
    apb(1'b0, ADDR_ACC, 32'h0);
    check(rd, {24'h0, p});
    apb(1'b1, ADDR_INSTR, ins(OP_BIT_SET, 1'b1, 3'h0, PORT_ADDR, 8'h00));
    apb(1'b0, ADDR_STATUS, 32'h0);
    check({24'h0, port_latch}, {24'h0, p | 8'h01});
    $display("port done");
    summarize();
  end
endmodule
